// *** inc/uosc_map.svh ***
// Register offsets, field positions, reset values and counts of the USB status and control block
`ifndef UOSC_MAP_SVH
`define UOSC_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define UOSC_OFF_ERR_FLAG 8'h00
`define UOSC_OFF_ERR_EN 8'h04
`define UOSC_OFF_INT_FLAG 8'h08
`define UOSC_OFF_INT_EN 8'h0c
`define UOSC_OFF_STAT 8'h10
`define UOSC_OFF_CON 8'h14
`define UOSC_OFF_ADDR 8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define UOSC_ERR_CRC5_EOF 1
`define UOSC_ERR_BTO 4
`define UOSC_INT_ERR 1
`define UOSC_INT_TRN 3
`define UOSC_CON_LIVE_J_LEVEL 7
`define UOSC_CON_SE0 6
`define UOSC_CON_PKT 5
`define UOSC_CON_RST 4
`define UOSC_CON_HOST 3
`define UOSC_CON_RESUME 2
`define UOSC_CON_PPRST 1
`define UOSC_CON_EN 0
`define UOSC_ADDR_LS 7
`define UOSC_ADDR_DEV_HI 6
`define UOSC_STAT_EP_HI 7
`define UOSC_STAT_EP_LO 4
`define UOSC_STAT_DIR 3
`define UOSC_STAT_ODD 2

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define UOSC_RST_BYTE 8'h00
`define UOSC_RST_ADDR7 7'h00
`define UOSC_BTO_LIMIT 5'h10
`define UOSC_FIFO_DEPTH 3'h4
`define UOSC_CNT_ZERO 3'h0
`define UOSC_CNT_ONE 3'h1
`define UOSC_PTR_ONE 2'h1

`endif

// *** inc/uosc_pkg.sv ***
// Types shared by the USB status and control block
package uosc_pkg;

    // One entry of the transaction status queue
    typedef struct packed {
        logic [3:0] endpoint;
        logic transmit;
        logic oddBank;
    } uosc_stat_t;

    // One register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } uosc_bus_t;

    // Turnaround watchdog states
    typedef enum logic [1:0] {
        BTO_IDLE,
        BTO_COUNT
    } uosc_bto_state_t;

endpackage : uosc_pkg

// *** rtl/uosc_status_control.sv ***
// USB dual-role controller: error masks, status queue, control and address registers
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`include "uosc_map.svh"

module uosc_status_control (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire uosc_pkg::uosc_bus_t busReq,
    output logic [31:0] rdData,
    input wire logic [7:0] errEvent,
    input wire logic bitTick,
    input wire logic eopDone,
    input wire logic respSeen,
    input wire logic sofCountZero,
    input wire logic linkActive,
    input wire logic tokenDone,
    input wire uosc_pkg::uosc_stat_t tokenStat,
    input wire logic setupSeen,
    input wire logic tokenExecuting,
    input wire logic dpPin,
    input wire logic dmPin,
    output logic usbIrq,
    output logic statFull,
    output logic pktHoldOut,
    output logic busResetDrive,
    output logic resumeDrive,
    output logic lsEopAppend,
    output logic hostLogicReset,
    output logic pingpongClear,
    output logic moduleEnable,
    output logic sofGenerate,
    output logic lowSpeedNext,
    output logic [6:0] functionAddress
);
    import uosc_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0] errFlag;
    logic [7:0] errEnable;
    logic [7:0] errSet;
    logic errSummary;
    logic errSummaryIe;
    logic trnIe;
    logic busReset;
    logic host_role_enable;
    logic hostEnPrev;
    logic resume;
    logic ppRst;
    logic enBit;
    logic pktHold;
    uosc_stat_t statMem [0:3];
    logic [1:0] wrPtr;
    logic [1:0] rdPtr;
    logic [2:0] count;
    logic [2:0] next_count;
    logic trnFlag;
    logic push;
    logic pop;
    logic [1:0] pinSync1;
    logic [1:0] pinSync2;
    logic jLevel;
    logic se0Level;
    uosc_bto_state_t btoState;
    logic [4:0] btoCount;
    logic btoEvent;
    logic frameEndEvent;
    logic wrErrFlag;
    logic wrErrEn;
    logic wrIntFlag;
    logic wrIntEn;
    logic wrCon;
    logic wrAddr;
    logic [31:0] readVal;
    logic [7:0] statByte;
    logic [7:0] conByte;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // Write strobes per register
    assign wrErrFlag = busReq.wr && (busReq.addr == `UOSC_OFF_ERR_FLAG);
    assign wrErrEn = busReq.wr && (busReq.addr == `UOSC_OFF_ERR_EN);
    assign wrIntFlag = busReq.wr && (busReq.addr == `UOSC_OFF_INT_FLAG);
    assign wrIntEn = busReq.wr && (busReq.addr == `UOSC_OFF_INT_EN);
    assign wrCon = busReq.wr && (busReq.addr == `UOSC_OFF_CON);
    assign wrAddr = busReq.wr && (busReq.addr == `UOSC_OFF_ADDR);

    // ----------------------------------------------------------------
    // Line state receiver
    // ----------------------------------------------------------------
    // Two-stage synchroniser for the bus pins
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pinSync1 <= 2'h0;
            pinSync2 <= 2'h0;
        end
        else
        begin
            pinSync1 <= {dpPin, dmPin};
            pinSync2 <= pinSync1;
        end
    end

    // J is D+ high at full speed, D- high at low speed
    assign jLevel = lowSpeedNext ? (pinSync2[0] & ~pinSync2[1]) : (pinSync2[1] & ~pinSync2[0]);
    assign se0Level = ~pinSync2[1] & ~pinSync2[0];

    // ----------------------------------------------------------------
    // Turnaround watchdog
    // ----------------------------------------------------------------
    // Counts idle bit-times after our end-of-packet until a response starts
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            btoState <= BTO_IDLE;
            btoCount <= 5'h00;
            btoEvent <= 1'b0;
        end
        else
        begin
            btoEvent <= 1'b0;
            case (btoState)
                BTO_IDLE:
                begin
                    btoCount <= 5'h00;
                    if (eopDone)
                    begin
                        btoState <= BTO_COUNT;
                    end
                end
                BTO_COUNT:
                begin
                    if (respSeen || hostLogicReset)
                    begin
                        btoState <= BTO_IDLE;
                    end
                    else if (bitTick)
                    begin
                        if (btoCount == `UOSC_BTO_LIMIT)
                        begin
                            btoEvent <= 1'b1;
                            btoState <= BTO_IDLE;
                        end
                        else
                        begin
                            btoCount <= btoCount + 5'h01;
                        end
                    end
                end
                default:
                begin
                    btoState <= BTO_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Error flags
    // ----------------------------------------------------------------
    // Host frame end error: still on the bus when the SOF counter runs out
    assign frameEndEvent = host_role_enable & sofCountZero & linkActive;

    // Event sources per flag; bit 1 changes meaning with the role
    always_comb
    begin
        errSet = errEvent;
        errSet[`UOSC_ERR_BTO] = btoEvent | errEvent[`UOSC_ERR_BTO];
        errSet[`UOSC_ERR_CRC5_EOF] = host_role_enable ? frameEndEvent : errEvent[`UOSC_ERR_CRC5_EOF];
    end

    // Sticky flags, write one to clear, a new event beats the clear
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_err
            always_ff @(posedge clk_sys or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    errFlag[gi] <= 1'b0;
                end
                else if (errSet[gi])
                begin
                    errFlag[gi] <= 1'b1;
                end
                else if (wrErrFlag && busReq.wdata[gi])
                begin
                    errFlag[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Error enable mask
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            errEnable <= `UOSC_RST_BYTE;
        end
        else if (wrErrEn)
        begin
            errEnable <= busReq.wdata[7:0];
        end
    end

    // Summary flag set only by enabled errors
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            errSummary <= 1'b0;
        end
        else if (|(errSet & errEnable))
        begin
            errSummary <= 1'b1;
        end
        else if (wrIntFlag && busReq.wdata[`UOSC_INT_ERR])
        begin
            errSummary <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt enables and request
    // ----------------------------------------------------------------
    // Summary and token-complete enables
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            errSummaryIe <= 1'b0;
            trnIe <= 1'b0;
        end
        else if (wrIntEn)
        begin
            errSummaryIe <= busReq.wdata[`UOSC_INT_ERR];
            trnIe <= busReq.wdata[`UOSC_INT_TRN];
        end
    end

    // Module interrupt request
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            usbIrq <= 1'b0;
        end
        else
        begin
            usbIrq <= (errSummary & errSummaryIe) | (trnFlag & trnIe);
        end
    end

    // ----------------------------------------------------------------
    // Transaction status queue
    // ----------------------------------------------------------------
    // Token-complete holds while any entry waits
    assign trnFlag = (count != `UOSC_CNT_ZERO);
    assign push = tokenDone && (count != `UOSC_FIFO_DEPTH);
    assign pop = wrIntFlag && busReq.wdata[`UOSC_INT_TRN] && trnFlag;

    // Occupancy after this cycle
    always_comb
    begin
        next_count = count;
        if (push && !pop)
        begin
            next_count = count + `UOSC_CNT_ONE;
        end
        else if (pop && !push)
        begin
            next_count = count - `UOSC_CNT_ONE;
        end
    end

    // Pointers, occupancy and full indication
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wrPtr <= 2'h0;
            rdPtr <= 2'h0;
            count <= `UOSC_CNT_ZERO;
            statFull <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                wrPtr <= wrPtr + `UOSC_PTR_ONE;
            end
            if (pop)
            begin
                rdPtr <= rdPtr + `UOSC_PTR_ONE;
            end
            count <= next_count;
            statFull <= (next_count == `UOSC_FIFO_DEPTH);
        end
    end

    // Entry storage
    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            statMem[wrPtr] <= tokenStat;
        end
    end

    // Head entry, zero when nothing waits
    always_comb
    begin
        statByte = `UOSC_RST_BYTE;
        if (trnFlag)
        begin
            statByte[`UOSC_STAT_EP_HI:`UOSC_STAT_EP_LO] = statMem[rdPtr].endpoint;
            statByte[`UOSC_STAT_DIR] = statMem[rdPtr].transmit;
            statByte[`UOSC_STAT_ODD] = statMem[rdPtr].oddBank;
        end
    end

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    // Software writable control bits
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busReset <= 1'b0;
            host_role_enable <= 1'b0;
            resume <= 1'b0;
            ppRst <= 1'b0;
            enBit <= 1'b0;
        end
        else if (wrCon)
        begin
            busReset <= busReq.wdata[`UOSC_CON_RST];
            host_role_enable <= busReq.wdata[`UOSC_CON_HOST];
            resume <= busReq.wdata[`UOSC_CON_RESUME];
            ppRst <= busReq.wdata[`UOSC_CON_PPRST];
            enBit <= busReq.wdata[`UOSC_CON_EN];
        end
    end

    // Device packet hold: SETUP sets it and wins over a clearing write
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pktHold <= 1'b0;
        end
        else if (host_role_enable)
        begin
            pktHold <= 1'b0;
        end
        else if (setupSeen)
        begin
            pktHold <= 1'b1;
        end
        else if (wrCon && !busReq.wdata[`UOSC_CON_PKT])
        begin
            pktHold <= 1'b0;
        end
    end

    // Readback of the control register
    always_comb
    begin
        conByte = `UOSC_RST_BYTE;
        conByte[`UOSC_CON_LIVE_J_LEVEL] = jLevel;
        conByte[`UOSC_CON_SE0] = se0Level;
        conByte[`UOSC_CON_PKT] = host_role_enable ? tokenExecuting : pktHold;
        conByte[`UOSC_CON_RST] = busReset;
        conByte[`UOSC_CON_HOST] = host_role_enable;
        conByte[`UOSC_CON_RESUME] = resume;
        conByte[`UOSC_CON_PPRST] = ppRst;
        conByte[`UOSC_CON_EN] = enBit;
    end

    // Bus side drives derived from the control bits
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hostEnPrev <= 1'b0;
            hostLogicReset <= 1'b0;
            busResetDrive <= 1'b0;
            resumeDrive <= 1'b0;
            lsEopAppend <= 1'b0;
            pingpongClear <= 1'b0;
            moduleEnable <= 1'b0;
            sofGenerate <= 1'b0;
            pktHoldOut <= 1'b0;
        end
        else
        begin
            hostEnPrev <= host_role_enable;
            hostLogicReset <= (host_role_enable != hostEnPrev);
            busResetDrive <= host_role_enable & busReset;
            resumeDrive <= resume;
            lsEopAppend <= host_role_enable & resumeDrive & ~resume;
            pingpongClear <= ppRst;
            moduleEnable <= ~host_role_enable & enBit;
            sofGenerate <= host_role_enable & enBit;
            pktHoldOut <= pktHold;
        end
    end

    // ----------------------------------------------------------------
    // Address register
    // ----------------------------------------------------------------
    // Speed select and function address
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lowSpeedNext <= 1'b0;
            functionAddress <= `UOSC_RST_ADDR7;
        end
        else if (wrAddr)
        begin
            lowSpeedNext <= busReq.wdata[`UOSC_ADDR_LS];
            functionAddress <= busReq.wdata[`UOSC_ADDR_DEV_HI:0];
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Read mux, unmapped offsets read zero
    always_comb
    begin
        readVal = 32'h0000_0000;
        case (busReq.addr)
            `UOSC_OFF_ERR_FLAG: readVal = {24'h00_0000, errFlag};
            `UOSC_OFF_ERR_EN: readVal = {24'h00_0000, errEnable};
            `UOSC_OFF_INT_FLAG: readVal = {28'h000_0000, trnFlag, 1'b0, errSummary, 1'b0};
            `UOSC_OFF_INT_EN: readVal = {28'h000_0000, trnIe, 1'b0, errSummaryIe, 1'b0};
            `UOSC_OFF_STAT: readVal = {24'h00_0000, statByte};
            `UOSC_OFF_CON: readVal = {24'h00_0000, conByte};
            `UOSC_OFF_ADDR: readVal = {24'h00_0000, lowSpeedNext, functionAddress};
            default: readVal = 32'h0000_0000;
        endcase
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdData <= 32'h0000_0000;
        end
        else
        begin
            rdData <= busReq.rd ? readVal : 32'h0000_0000;
        end
    end

endmodule : uosc_status_control

// *** testbench/uosc_cable_model.sv ***
// Cable side: line levels, bit times and the far end's answer
`timescale 1ns/1ns

module uosc_cable_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [1:0] lineState,
    input wire logic [4:0] replyAfter,
    input wire logic eopDone,
    output logic dpPin,
    output logic dmPin,
    output logic bitTick,
    output logic respSeen
);
    logic [1:0] div;
    logic [4:0] ticks;
    logic armed;

    // Lines: 0 idle J, 1 K, 2 single-ended zero
    assign dpPin = lineState == 2'h0;
    assign dmPin = lineState == 2'h1;
    assign bitTick = div == 2'h3;

    // One bit time per four system clocks
    always_ff @(posedge clk_sys or negedge rst_n)
        if (!rst_n)
            div <= 2'h0;
        else
            div <= div + 2'h1;

    // Answer after replyAfter bit times; zero never answers
    always_ff @(posedge clk_sys or negedge rst_n)
        if (!rst_n)
        begin
            ticks <= 5'h00;
            armed <= 1'b0;
            respSeen <= 1'b0;
        end
        else
        begin
            respSeen <= 1'b0;
            if (eopDone)
            begin
                armed <= 1'b1;
                ticks <= 5'h00;
            end
            else if (armed && replyAfter != 5'h00 && ticks == replyAfter)
            begin
                armed <= 1'b0;
                respSeen <= 1'b1;
            end
            else if (armed && bitTick)
                ticks <= ticks + 5'h01;
        end
endmodule : uosc_cable_model

// *** testbench/uosc_status_control_assertions.sv ***
// Checker of the USB status and control block ports
`timescale 1ns/1ns
`include "uosc_map.svh"

module uosc_sc_checker (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire uosc_pkg::uosc_bus_t busReq,
    input wire logic [7:0] errEvent,
    input wire logic tokenDone,
    input wire logic usbIrq,
    input wire logic statFull,
    input wire logic busResetDrive,
    input wire logic resumeDrive,
    input wire logic lsEopAppend,
    input wire logic hostLogicReset,
    input wire logic pingpongClear,
    input wire logic moduleEnable,
    input wire logic sofGenerate,
    input wire logic lowSpeedNext,
    input wire logic [6:0] functionAddress
);
    import uosc_pkg::*;
    logic [4:0] conW;
    logic [7:0] errEnW;
    logic ieErr;
    logic [2:0] occ;
    logic push;
    logic pop;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Queue pushes and pops as the block should take them
    assign push = tokenDone && occ != 3'h4;
    assign pop = busReq.wr && busReq.addr == `UOSC_OFF_INT_FLAG && busReq.wdata[3] && occ != 3'h0;

    // Shadows of what software wrote, and queue fill
    always_ff @(posedge clk_sys or negedge rst_n)
        if (!rst_n)
        begin
            conW <= 5'h00;
            errEnW <= 8'h00;
            ieErr <= 1'b0;
            occ <= 3'h0;
        end
        else
        begin
            if (busReq.wr && busReq.addr == `UOSC_OFF_CON)
                conW <= busReq.wdata[4:0];
            if (busReq.wr && busReq.addr == `UOSC_OFF_ERR_EN)
                errEnW <= busReq.wdata[7:0];
            if (busReq.wr && busReq.addr == `UOSC_OFF_INT_EN)
                ieErr <= busReq.wdata[1];
            occ <= occ + 3'(push) - 3'(pop);
        end

    chk_queue_full: assert property (statFull == (occ == 3'h4))
        else $error("queue full flag wrong");
    chk_addr_load: assert property (busReq.wr && busReq.addr == `UOSC_OFF_ADDR |=>
        {lowSpeedNext, functionAddress} == $past(busReq.wdata[7:0]))
        else $error("address not loaded");
    chk_pp_follow: assert property (pingpongClear == $past(conW[1]))
        else $error("pointer clear wrong");
    chk_resume_follow: assert property (resumeDrive == $past(conW[2]))
        else $error("resume drive wrong");
    chk_reset_drive: assert property (busResetDrive == $past(conW[4] & conW[3]))
        else $error("bus reset wrong");
    chk_role_enable: assert property ({sofGenerate, moduleEnable} ==
        $past({conW[3] & conW[0], !conW[3] & conW[0]}))
        else $error("enable split wrong");
    chk_host_toggle: assert property ($changed(conW[3]) |-> ##[1:2] hostLogicReset)
        else $error("no host reset");
    chk_eop_append: assert property ($fell(resumeDrive) && conW[3] |-> ##[0:1] lsEopAppend)
        else $error("no low speed end");
    chk_err_irq: assert property ((errEvent & errEnW & 8'hfd) != 8'h00 && ieErr |-> ##2 usbIrq)
        else $error("error irq missing");

    // Main scenarios reached
    cover property (statFull && tokenDone);
    cover property (lsEopAppend);
    cover property (hostLogicReset);
endmodule : uosc_sc_checker

bind uosc_status_control uosc_sc_checker chk_u (
    .clk_sys, .rst_n, .busReq, .errEvent, .tokenDone, .usbIrq, .statFull, .busResetDrive, .resumeDrive,
    .lsEopAppend, .hostLogicReset, .pingpongClear, .moduleEnable, .sofGenerate, .lowSpeedNext, .functionAddress
);

// *** testbench/uosc_status_control_bench.sv ***
// Self-checking bench of the USB status and control block
`timescale 1ns/1ns
`include "uosc_map.svh"

module uosc_status_control_bench;
    import uosc_pkg::*;
    localparam logic [7:0] OEF = `UOSC_OFF_ERR_FLAG;
    localparam logic [7:0] OEE = `UOSC_OFF_ERR_EN;
    localparam logic [7:0] OIF = `UOSC_OFF_INT_FLAG;
    localparam logic [7:0] OIE = `UOSC_OFF_INT_EN;
    localparam logic [7:0] OST = `UOSC_OFF_STAT;
    localparam logic [7:0] OCN = `UOSC_OFF_CON;
    localparam logic [7:0] OAD = `UOSC_OFF_ADDR;
    logic clk_sys, rst_n, bitTick, eopDone, respSeen, sofCountZero, linkActive, tokenDone, setupSeen;
    logic tokenExecuting, dpPin, dmPin, usbIrq, statFull, pktHoldOut, busResetDrive, resumeDrive;
    logic lsEopAppend, hostLogicReset, pingpongClear, moduleEnable, sofGenerate, lowSpeedNext;
    logic [6:0] functionAddress;
    logic [7:0] errEvent;
    logic [31:0] rdData;
    logic [1:0] lineState;
    logic [4:0] replyAfter;
    uosc_bus_t busReq;
    uosc_stat_t tokenStat;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;

    uosc_status_control dut_u (.*);
    uosc_cable_model cable_u (.*);

    // System clock
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Cut a hung run short
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            mismatches++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== {24'h0, exp})
        begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        tick(1);
        busReq.wr <= 1'b0;
        tick(1);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        tick(1);
        busReq.rd <= 1'b0;
        tick(1);
        chk(rdData, exp);
    endtask : rdc

    task automatic t_regs;
        rdc(OEE, 8'h00);
        rdc(OAD, 8'h00);
        rdc(OST, 8'h00);
        wr(OEE, 32'hffff_ff5a);
        rdc(OEE, 8'h5a);
        rdc(OCN, 8'h80);
        wr(OAD, 32'h0000_01d3);
        rdc(OAD, 8'hd3);
        chk(lowSpeedNext, 8'h01);
        rdc(OCN, 8'h00);
        wr(OAD, 32'h2a);
        chk(functionAddress, 8'h2a);
        rdc(8'h40, 8'h00);
        $display("registers done");
    endtask : t_regs

    task automatic t_queue;
        wr(OIE, 32'h08);
        for (int i = 0; i < 5; i++)
        begin
            tokenDone <= 1'b1;
            tokenStat <= '{endpoint: 4'(15 - 5 * i), transmit: i[0], oddBank: i[1]};
            tick(1);
        end
        tokenDone <= 1'b0;
        tick(2);
        chk(statFull, 8'h01);
        chk(usbIrq, 8'h01);
        for (int i = 0; i < 4; i++)
        begin
            rdc(OIF, 8'h08);
            rdc(OST, {4'(15 - 5 * i), i[0], i[1], 2'b00});
            wr(OIF, 32'h08);
        end
        rdc(OIF, 8'h00);
        rdc(OST, 8'h00);
        chk(usbIrq, 8'h00);
        $display("queue done");
    endtask : t_queue

    task automatic t_err;
        wr(OEE, 32'h04);
        wr(OIE, 32'h02);
        errEvent <= 8'h84;
        tick(1);
        errEvent <= 8'h00;
        tick(3);
        chk(usbIrq, 8'h01);
        rdc(OEF, 8'h84);
        wr(OEF, 32'h84);
        wr(OIF, 32'h02);
        errEvent <= 8'h80;
        tick(1);
        errEvent <= 8'h00;
        rdc(OIF, 8'h00);
        chk(usbIrq, 8'h00);
        wr(OIE, 32'h00);
        errEvent <= 8'h04;
        tick(1);
        errEvent <= 8'h00;
        rdc(OIF, 8'h02);
        chk(usbIrq, 8'h00);
        wr(OEF, 32'hff);
        wr(OIF, 32'h02);
        $display("errors done");
    endtask : t_err

    task automatic t_bto;
        int tab[3] = '{0, 16, 17};
        wr(OEE, 32'h10);
        foreach (tab[k])
        begin
            replyAfter <= 5'(tab[k]);
            eopDone <= 1'b1;
            tick(1);
            eopDone <= 1'b0;
            tick(90);
            rdc(OEF, tab[k] == 16 ? 8'h00 : 8'h10);
            wr(OEF, 32'hff);
        end
        $display("turnaround done");
    endtask : t_bto

    task automatic t_frame;
        wr(OEE, 32'h02);
        linkActive <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            wr(OCN, {28'h0, i[1], 3'h0});
            errEvent <= {6'h0, ~i[0], 1'b0};
            sofCountZero <= i[0];
            tick(1);
            errEvent <= 8'h00;
            sofCountZero <= 1'b0;
            rdc(OEF, (i == 0 || i == 3) ? 8'h02 : 8'h00);
            wr(OEF, 32'hff);
        end
        linkActive <= 1'b0;
        $display("frame end done");
    endtask : t_frame

    task automatic t_ctrl;
        wr(OCN, 32'h00);
        rdc(OCN, 8'h80);
        lineState <= 2'h2;
        tick(3);
        rdc(OCN, 8'h40);
        lineState <= 2'h1;
        setupSeen <= 1'b1;
        tick(1);
        setupSeen <= 1'b0;
        tick(3);
        rdc(OCN, 8'h20);
        chk(pktHoldOut, 8'h01);
        wr(OCN, 32'h00);
        rdc(OCN, 8'h00);
        wr(OCN, 32'h1f);
        tokenExecuting <= 1'b1;
        rdc(OCN, 8'h3f);
        chk(busResetDrive, 8'h01);
        chk(resumeDrive, 8'h01);
        chk(pingpongClear, 8'h01);
        chk(sofGenerate, 8'h01);
        tokenExecuting <= 1'b0;
        rdc(OCN, 8'h1f);
        // Resume dropped after a short hold; how long it stands is left to software
        wr(OCN, 32'h0b);
        tick(1);
        chk(lsEopAppend, 8'h01);
        tick(2);
        wr(OCN, 32'h01);
        tick(1);
        chk(hostLogicReset, 8'h01);
        chk(moduleEnable, 8'h01);
        tick(2);
        lineState <= 2'h0;
        $display("control done");
    endtask : t_ctrl

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results

    // Reset, then the scenarios
    initial
    begin
        rst_n = 1'b0;
        busReq = '0;
        errEvent = 8'h00;
        {eopDone, sofCountZero, linkActive, tokenDone, setupSeen, tokenExecuting} = 6'h00;
        tokenStat = '0;
        lineState = 2'h0;
        replyAfter = 5'h00;
        tick(8);
        rst_n <= 1'b1;
        tick(1);
        t_regs();
        t_queue();
        t_err();
        t_bto();
        t_frame();
        t_ctrl();
        results();
    end
endmodule : uosc_status_control_bench
